//--- bench/sclk_rc_net.sv
/*
 external oscillator network model driving the clock input pin.
 assumes run follows reset; pin rests low while stopped.
*/
`timescale 1ns/10ps
module sclk_rc_net #(
  parameter int HALF_NS = 530
) (
  input wire logic run,
  output logic pin
);
  // half period off the mclk grid, yet every fifth pin edge (2650 ns) still lands on an mclk edge
  initial pin = 1'b0;
  always begin
    wait (run);
    #(HALF_NS) pin = 1'b1;
    #(HALF_NS) pin = 1'b0;
  end
endmodule // sclk_rc_net

//--- bench/sclk_source_select_sva.sv
/*
 port assertions for the clock source select block.
 assumes one mclk domain; bound to every sclk_source_select instance.
*/
`timescale 1ns/10ps
module sclk_source_select_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] osc_mode,
  input wire logic system_clock_select_wr,
  input wire logic system_clock_select_in,
  input wire logic system_clock_select,
  input wire logic hf_osc_stable_flag,
  input wire logic ext_osc_ready_flag,
  input wire logic sys_clk_en,
  input wire logic clock_output_pin_out,
  input wire logic clock_output_pin_oe,
  input wire logic clock_input_pin_gpio,
  input wire logic clock_output_pin_gpio
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_SEL_WRITE: assert property (system_clock_select_wr |=>
    system_clock_select == $past(system_clock_select_in)) else $error("select write lost");
  AST_SEL_HOLD: assert property (!system_clock_select_wr |=>
    $stable(system_clock_select)) else $error("select moved without write");
  AST_SEL_RESET: assert property ($rose(nrst) |-> !system_clock_select)
    else $error("select set after reset");
  AST_OUT_DRIVE: assert property (clock_output_pin_oe == (osc_mode inside {3'h5, 3'h7}))
    else $error("output pin drive wrong");
  AST_IN_GPIO: assert property (clock_input_pin_gpio == (osc_mode inside {3'h4, 3'h5}))
    else $error("input pin gpio wrong");
  AST_OUT_GPIO: assert property (clock_output_pin_gpio == (osc_mode inside {3'h4, 3'h6}))
    else $error("output pin gpio wrong");
  AST_CLKOUT_STEP: assert property (!sys_clk_en |=> $stable(clock_output_pin_out))
    else $error("clock output moved without system clock");
  AST_READY_MODE: assert property (ext_osc_ready_flag |-> osc_mode < 3'h3)
    else $error("ready flag outside crystal modes");
  // sixteen hf ticks are needed, so eight quiet cycles is a safe floor
  AST_HF_SETTLE: assert property ($rose(nrst) |-> !hf_osc_stable_flag [*8])
    else $error("hf stable too early");
endmodule // sclk_source_select_sva
bind sclk_source_select sclk_source_select_sva sclk_source_select_sva_i (.*);

//--- bench/test_system_clock_source_select.sv
/*
 self-checking bench: counts system clock enables against a rate model.
 assumes the partner network period of 1060 ns and hf divider from the package.
*/
`timescale 1ns/10ps
module test_system_clock_source_select;
  localparam int W = 1288;
  localparam int EXT_NS = 1060;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] osc_mode = 3'h5;
  logic two_speed = 1'b0;
  logic sel_wr = 1'b0;
  logic sel_in = 1'b0;
  logic [2:0] internal_freq_select = 3'h7;
  logic [5:0] hf_osc_tuning = 6'h00;
  logic ext_pin, system_clock_select, hf_osc_stable_flag, ext_osc_ready_flag, sys_clk_en;
  logic clock_output_pin_out, clock_output_pin_oe, clock_input_pin_gpio, clock_output_pin_gpio;
  logic sel_m = 1'b0;
  logic ost_done = 1'b0;
  int fails = 0;
  int checks = 0;
  int i, c;
  always #50 mclk = ~mclk;
  sclk_rc_net sclk_rc_net_i (.run(nrst), .pin(ext_pin));
  sclk_source_select sclk_source_select_i (.mclk(mclk), .nrst(nrst), .osc_mode(osc_mode),
    .two_speed_startup_enable(two_speed), .system_clock_select_wr(sel_wr),
    .system_clock_select_in(sel_in), .internal_freq_select(internal_freq_select),
    .hf_osc_tuning(hf_osc_tuning), .ext_osc_pin(ext_pin),
    .system_clock_select(system_clock_select), .hf_osc_stable_flag(hf_osc_stable_flag),
    .ext_osc_ready_flag(ext_osc_ready_flag), .sys_clk_en(sys_clk_en),
    .clock_output_pin_out(clock_output_pin_out), .clock_output_pin_oe(clock_output_pin_oe),
    .clock_input_pin_gpio(clock_input_pin_gpio), .clock_output_pin_gpio(clock_output_pin_gpio));
  task automatic close_out();
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s exp %b got %b", nm, e, g);
    end
  endtask
  // window edges may cut one period either way
  task automatic check_num(input string nm, input int e, input int g);
    checks++;
    if (g > e + 1 || g < e - 1) begin
      fails++;
      $display("Error %s exp %0d got %0d", nm, e, g);
    end
  endtask
  function automatic int exp_en();
    int per;
    if (!sel_m && !(osc_mode inside {3'h4, 3'h5}) && (osc_mode >= 3'h3 || ost_done))
      return W * 100 / EXT_NS;
    if (internal_freq_select == 3'h0) return W / sclk_pkg::LF_DIV;
    per = sclk_pkg::HF_DIV + int'(hf_osc_tuning);
    if (per < 1) per = 1;
    return W / (per << (7 - int'(internal_freq_select)));
  endfunction
  task automatic run_chk();
    int n, t;
    logic last;
    n = 0;
    t = 0;
    repeat (400) @(negedge mclk);
    last = clock_output_pin_out;
    repeat (W) begin
      @(negedge mclk);
      n += int'(sys_clk_en === 1'b1);
      t += int'(clock_output_pin_out !== last);
      last = clock_output_pin_out;
    end
    check_num("sys_clk_en", exp_en(), n);
    if (osc_mode inside {3'h5, 3'h7}) check_num("clkout", exp_en() / 2, t);
  endtask
  task automatic do_reset(input logic [2:0] m, input logic ts);
    nrst = 1'b0;
    osc_mode = m;
    two_speed = ts;
    sel_m = 1'b0;
    ost_done = 1'b0;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    check_bit("sel_reset", 1'b0, system_clock_select);
  endtask
  task automatic wr_sel(input logic v);
    sel_wr = 1'b1;
    sel_in = v;
    sel_m = v;
    @(negedge mclk);
    sel_wr = 1'b0;
    @(negedge mclk);
    check_bit("sel", v, system_clock_select);
  endtask
  initial begin
    #(80000 * 100);
    fails++;
    close_out();
  end
  initial begin
    void'($urandom(32'h5C7E));
    do_reset(3'h5, 1'b0);
    for (i = 0; i < 8; i++) begin
      osc_mode = i[2:0];
      @(negedge mclk);
      check_bit("oe", i == 5 || i == 7, clock_output_pin_oe);
      check_bit("in_io", i == 4 || i == 5, clock_input_pin_gpio);
      check_bit("out_io", i == 4 || i == 6, clock_output_pin_gpio);
    end
    do_reset(3'h5, 1'b0);
    for (i = 0; i < 8; i++) begin
      internal_freq_select = i[2:0];
      run_chk();
    end
    hf_osc_tuning = 6'($urandom % 4);
    run_chk();
    hf_osc_tuning = 6'h00;
    for (i = 0; i < 3; i++) begin
      do_reset(i == 0 ? 3'h3 : 3'(i + 5), 1'b0);
      run_chk();
      internal_freq_select = 3'($urandom % 8);
      wr_sel(1'b1);
      run_chk();
      check_bit("ready_rc", 1'b0, ext_osc_ready_flag);
    end
    internal_freq_select = 3'h7;
    do_reset(3'h1, 1'b0);
    repeat (300) @(negedge mclk);
    check_bit("hf_off", 1'b0, hf_osc_stable_flag);
    wr_sel(1'b1);
    repeat (40) @(negedge mclk);
    check_bit("hf_on", 1'b1, hf_osc_stable_flag);
    do_reset(3'h1, 1'b1);
    run_chk();
    c = 1688;
    while (ext_osc_ready_flag !== 1'b1 && c < 12000) begin
      @(negedge mclk);
      c++;
    end
    check_bit("ost_time", 1'b1, c >= 10840 && c <= 11300);
    check_bit("ready", 1'b1, ext_osc_ready_flag);
    check_bit("sel_auto", 1'b0, system_clock_select);
    ost_done = 1'b1;
    run_chk();
    close_out();
  end
endmodule // test_system_clock_source_select

//--- rtl/sclk_int_osc.sv
/*
 internal oscillators: tunable hf tick and free lf tick from mclk dividers.
 assumes mclk is the only clock; ticks are one-cycle enables.
*/
`timescale 1ns/10ps
module sclk_int_osc (
  input wire logic mclk,
  input wire logic nrst,
  sclk_osc_if.osc o
);
  logic [7:0] hf_cnt_q;
  logic [11:0] lf_cnt_q;
  logic [4:0] stab_q;
  logic [7:0] hf_top;

  // tuning stretches the hf period; two's complement offset, clamp at one cycle
  always_comb begin
    hf_top = 8'(sclk_pkg::HF_DIV - 1) + {{2{o.tune[5]}}, o.tune};
    if (o.tune[5] && (8'(sclk_pkg::HF_DIV - 1) < 8'(-$signed(o.tune)))) begin
      hf_top = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hf_cnt_q <= 8'h00;
    end else if (!o.hf_en || hf_cnt_q >= hf_top) begin
      hf_cnt_q <= 8'h00;
    end else begin
      hf_cnt_q <= hf_cnt_q + 8'h01;
    end
  end
  assign o.hf_tick = o.hf_en && (hf_cnt_q >= hf_top);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lf_cnt_q <= 12'h000;
    end else if (lf_cnt_q == 12'(sclk_pkg::LF_DIV - 1)) begin
      lf_cnt_q <= 12'h000;
    end else begin
      lf_cnt_q <= lf_cnt_q + 12'h001;
    end
  end
  assign o.lf_tick = (lf_cnt_q == 12'(sclk_pkg::LF_DIV - 1));

  // stable after a fixed number of hf periods; drops when hf is stopped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stab_q <= 5'h00;
    end else if (!o.hf_en) begin
      stab_q <= 5'h00;
    end else if (o.hf_tick && stab_q != 5'(sclk_pkg::HF_STABLE_CYCLES)) begin
      stab_q <= stab_q + 5'h01;
    end
  end
  assign o.hf_stable = (stab_q == 5'(sclk_pkg::HF_STABLE_CYCLES));
endmodule // sclk_int_osc

//--- rtl/sclk_osc_if.sv
/*
 interface carrying internal oscillator ticks between the top and the oscillator model.
 assumes both ends run on mclk.
*/
`timescale 1ns/10ps
interface sclk_osc_if;
  logic hf_en;
  logic [5:0] tune;
  logic hf_tick;
  logic lf_tick;
  logic hf_stable;
  modport ctrl (output hf_en, output tune, input hf_tick, input lf_tick, input hf_stable);
  modport osc (input hf_en, input tune, output hf_tick, output lf_tick, output hf_stable);
endinterface

//--- rtl/sclk_pkg.sv
/*
 clock source select package: oscillator modes, states, timing constants.
 assumes one 10 MHz mclk domain; all oscillators are modelled as enable pulses.
*/
package sclk_pkg;
  typedef enum logic [2:0] {
    SCLK_MODE_LP = 3'h0,
    SCLK_MODE_XT = 3'h1,
    SCLK_MODE_HS = 3'h2,
    SCLK_MODE_EC = 3'h3,
    SCLK_MODE_INTIO = 3'h4,
    SCLK_MODE_INTCK = 3'h5,
    SCLK_MODE_RESISTOR_CAPACITOR_IO_MODE = 3'h6,
    SCLK_MODE_RCCK = 3'h7
  } sclk_mode_t;

  typedef enum logic [1:0] {
    SCLK_ST_INT = 2'h0,
    SCLK_ST_OST = 2'h1,
    SCLK_ST_WAIT = 2'h2,
    SCLK_ST_EXT = 2'h3
  } sclk_state_t;

  localparam int MCLK_HZ = 10000000;
  localparam int HF_HZ = 8000000;
  localparam int LF_HZ = 31000;
  // hf period in mclk cycles, rounded down (shortest time), at least one
  localparam int HF_DIV_CALC = MCLK_HZ / HF_HZ;
  localparam int HF_DIV = (HF_DIV_CALC < 1) ? 1 : HF_DIV_CALC;
  localparam int LF_DIV_CALC = MCLK_HZ / LF_HZ;
  localparam int LF_DIV = (LF_DIV_CALC < 1) ? 1 : LF_DIV_CALC;
  localparam int OST_COUNT = 1024;
  localparam int HF_STABLE_CYCLES = 16;
  localparam logic [2:0] FREQ_SEL_LF = 3'h0;
  localparam logic [5:0] TUNE_RESET = 6'h00;
  localparam logic SEL_RESET = 1'b0;
endpackage

//--- rtl/sclk_source_select.sv
/*
 system clock source select: modes, postscaler, select bit, start-up timer,
 glitch-free switch, clock output pin divide by 4.
 assumes ext_osc_pin is an asynchronous pin sampled on mclk; the system clock
 is delivered as a one-cycle enable pulse sys_clk_en on mclk.
*/
`timescale 1ns/10ps
module sclk_source_select (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] osc_mode,
  input wire logic two_speed_startup_enable,
  input wire logic system_clock_select_wr,
  input wire logic system_clock_select_in,
  input wire logic [2:0] internal_freq_select,
  input wire logic [5:0] hf_osc_tuning,
  input wire logic ext_osc_pin,
  output logic system_clock_select,
  output logic hf_osc_stable_flag,
  output logic ext_osc_ready_flag,
  output logic sys_clk_en,
  output logic clock_output_pin_out,
  output logic clock_output_pin_oe,
  output logic clock_input_pin_gpio,
  output logic clock_output_pin_gpio
);
  sclk_osc_if osc_bus ();
  sclk_int_osc u_osc (
    .mclk(mclk),
    .nrst(nrst),
    .o(osc_bus)
  );

  sclk_pkg::sclk_mode_t mode;
  sclk_pkg::sclk_state_t state_q;
  logic sel_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic ext_rise;
  logic [6:0] post_q;
  logic int_tick;
  logic [10:0] ost_q;
  logic crystal;
  logic ext_src, use_ext_q;
  logic div4_q;
  logic clkout_q;

  assign mode = sclk_pkg::sclk_mode_t'(osc_mode);
  // only crystal modes need the start-up timer; rc and ec run at once
  assign crystal = (mode == sclk_pkg::SCLK_MODE_LP) || (mode == sclk_pkg::SCLK_MODE_XT) ||
                   (mode == sclk_pkg::SCLK_MODE_HS);

  // two flops before the edge detector; ext_s1_q feeds only ext_s2_q
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_osc_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  assign ext_rise = ext_s2_q && !ext_s3_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= sclk_pkg::SEL_RESET;
    end else if (system_clock_select_wr) begin
      sel_q <= system_clock_select_in;
    end
  end
  assign system_clock_select = sel_q;

  assign osc_bus.hf_en = (internal_freq_select != sclk_pkg::FREQ_SEL_LF) &&
                         (sel_q || two_speed_startup_enable ||
                          !(crystal || mode == sclk_pkg::SCLK_MODE_EC ||
                            mode == sclk_pkg::SCLK_MODE_RESISTOR_CAPACITOR_IO_MODE ||
                            mode == sclk_pkg::SCLK_MODE_RCCK));
  assign osc_bus.tune = hf_osc_tuning;
  assign hf_osc_stable_flag = osc_bus.hf_stable;

  // postscaler: free-running counter of hf ticks, bit k toggles at (10 MHz/HF_DIV)/2^(k+1)
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      post_q <= 7'h00;
    end else if (osc_bus.hf_tick) begin
      post_q <= post_q + 7'h01;
    end
  end

  function automatic logic post_tick(input logic [2:0] fsel, input logic [6:0] cnt,
                                     input logic tick);
    logic [6:0] mask;
    mask = 7'h00;
    if (fsel != 3'h7) begin
      mask = 7'((7'h01 << (3'h7 - fsel)) - 7'h01);
    end
    post_tick = tick && ((cnt & mask) == mask);
  endfunction

  always_comb begin
    if (internal_freq_select == sclk_pkg::FREQ_SEL_LF) begin
      int_tick = osc_bus.lf_tick;
    end else begin
      int_tick = post_tick(internal_freq_select, post_q, osc_bus.hf_tick);
    end
  end

  // start-up timer: count external edges in crystal modes, then with two-speed start-up wait an internal tick
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= sclk_pkg::SCLK_ST_INT;
      ost_q <= 11'h000;
    end else begin
      case (state_q)
        sclk_pkg::SCLK_ST_INT: begin
          ost_q <= 11'h000;
          if (crystal) begin
            state_q <= sclk_pkg::SCLK_ST_OST;
          end
        end
        sclk_pkg::SCLK_ST_OST: begin
          if (!crystal) begin
            state_q <= sclk_pkg::SCLK_ST_INT;
          end else if (ext_rise) begin
            ost_q <= ost_q + 11'h001;
            if (ost_q == 11'(sclk_pkg::OST_COUNT - 1)) begin
              state_q <= sclk_pkg::SCLK_ST_WAIT;
            end
          end
        end
        sclk_pkg::SCLK_ST_WAIT: begin
          if (int_tick || !two_speed_startup_enable) begin
            state_q <= sclk_pkg::SCLK_ST_EXT;
          end
        end
        sclk_pkg::SCLK_ST_EXT: begin
          if (!crystal) begin
            state_q <= sclk_pkg::SCLK_ST_INT;
          end
        end
        default: begin
          state_q <= sclk_pkg::SCLK_ST_INT;
        end
      endcase
    end
  end
  // gated by mode so that leaving the crystal modes drops the flag in the same cycle
  assign ext_osc_ready_flag = (state_q == sclk_pkg::SCLK_ST_EXT) && crystal;

  // wanted source: external unless select bit set, internal modes, or crystal not yet ready
  always_comb begin
    ext_src = 1'b0;
    if (!sel_q) begin
      case (mode)
        sclk_pkg::SCLK_MODE_EC, sclk_pkg::SCLK_MODE_RESISTOR_CAPACITOR_IO_MODE,
        sclk_pkg::SCLK_MODE_RCCK: ext_src = 1'b1;
        sclk_pkg::SCLK_MODE_LP, sclk_pkg::SCLK_MODE_XT,
        sclk_pkg::SCLK_MODE_HS: ext_src = ext_osc_ready_flag;
        default: ext_src = 1'b0;
      endcase
    end
  end

  // switch only on a tick of the new source, so no pulse is cut short
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      use_ext_q <= 1'b0;
    end else if (ext_src != use_ext_q) begin
      // sys_clk_en is gated off meanwhile; a slow new source gives a long low phase,
      // never a short one
      if ((ext_src && ext_rise) || (!ext_src && int_tick)) begin
        use_ext_q <= ext_src;
      end
    end
  end
  // the old source stops the moment the wanted source differs from the one in use
  assign sys_clk_en = (use_ext_q == ext_src) && (use_ext_q ? ext_rise : int_tick);

  // clock output: toggles every two system clocks, giving fosc/4
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div4_q <= 1'b0;
      clkout_q <= 1'b0;
    end else if (sys_clk_en) begin
      div4_q <= ~div4_q;
      if (div4_q) begin
        clkout_q <= ~clkout_q;
      end
    end
  end

  assign clock_output_pin_out = clkout_q;
  assign clock_output_pin_oe = (mode == sclk_pkg::SCLK_MODE_RCCK) ||
                               (mode == sclk_pkg::SCLK_MODE_INTCK);
  assign clock_output_pin_gpio = (mode == sclk_pkg::SCLK_MODE_RESISTOR_CAPACITOR_IO_MODE) ||
                                 (mode == sclk_pkg::SCLK_MODE_INTIO);
  assign clock_input_pin_gpio = (mode == sclk_pkg::SCLK_MODE_INTIO) ||
                                (mode == sclk_pkg::SCLK_MODE_INTCK);
endmodule // sclk_source_select
